// *** hdl/timer_cfg.svh ***
`ifndef TIMER_CFG_SVH
`define TIMER_CFG_SVH
// register byte addresses
`define ADDR_CONTROL 4'h0
`define ADDR_COUNTER 4'h4
`define ADDR_RELOAD 4'h8
`define ADDR_COMPARE 4'hC
// control word bit positions
`define BIT_CAPTURE 0
`define BIT_INT_EN 1
`define BIT_RUN 2
`define BIT_EXT_EN 3
`define BIT_DOWN_EN 4
`define BIT_OUT_A_EN 5
`define BIT_EXT_FLAG 6
`define BIT_OVF_FLAG 7
`define BIT_PRESCALE_LO 8
`define BIT_PRESCALE_HI 10
`define BIT_PWM_CLR 11
`define BIT_PWM_SET 12
`define BIT_COUNTER_MODE 15
// reset values
`define CONTROL_RESET 16'h0000
`define COUNTER_RESET 16'h0000
`define RELOAD_RESET 16'h0000
`define COMPARE_RESET 16'h0000
`endif

// *** hdl/timer_pkg.sv ***
package timer_pkg;
   typedef logic [15:0] word_t;
   typedef logic [2:0] prescale_t;
endpackage

// *** hdl/timer_prescaler.sv ***
`timescale 1ns/1ns
`include "timer_cfg.svh"
module timer_prescaler (
   input wire logic clk,
   input wire logic reset,
   input wire timer_pkg::prescale_t prescaleSelect,
   output logic tick
);
   logic [9:0] div_reg;
   logic [9:0] div_next;
   logic [9:0] limit;

   // codes six and seven fall back to divide by one
   function automatic logic [9:0] divLimit(input timer_pkg::prescale_t code);
      case (code)
         3'h1: divLimit = 10'h003;
         3'h2: divLimit = 10'h00F;
         3'h3: divLimit = 10'h03F;
         3'h4: divLimit = 10'h0FF;
         3'h5: divLimit = 10'h3FF;
         default: divLimit = 10'h000;
      endcase
   endfunction

   always_comb begin
      limit = divLimit(prescaleSelect); // R8
      tick = (div_reg >= limit);
      div_next = tick ? 10'h000 : div_reg + 10'h001;
   end

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         div_reg <= 10'h000;
      end else begin
         div_reg <= div_next;
      end
   end
endmodule

// *** hdl/timer_sync.sv ***
`timescale 1ns/1ns
module timer_sync (
   input wire logic clk,
   input wire logic reset,
   input wire logic din,
   output logic dout
);
   logic meta_reg;
   logic sync_reg;
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         meta_reg <= 1'b0;
         sync_reg <= 1'b0;
      end else begin
         meta_reg <= din;
         sync_reg <= meta_reg;
      end
   end
   assign dout = sync_reg;
endmodule

// *** hdl/timer_square_wave_pwm.sv ***
// Design decisions made here: the Wishbone interface to the registers and the register offsets.
`timescale 1ns/1ns
`include "timer_cfg.svh"
// Operation
// R1: reload mode with pin A enabled: toggle pin A at every reload.
// R2: control word 0x0024 gives timer, no PWM, divide one, square wave on A.
// R3: control word 0x0804 gives timer with PWM on pin B, divide one.
// R4: PWM pin B high from zero to compare minus one, low at compare.
// R5: PWM counter runs past compare to reload value, then restarts at zero.
// R6: up count reloads zero at reload value; down count reloads value at zero.
// R7: overflow flag set on each overflow or underflow, held until cleared.
// R8: prescale codes 0..5 divide by 1,4,16,64,256,1024; 6 and 7 by one.
// R9: clear-on-compare PWM drives B low at compare, high at reload value.
// R10: writes act next clock; counter write never raises overflow flag.
module timer_square_wave_pwm (
   input wire logic clk,
   input wire logic reset,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [3:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   input wire logic pinAIn,
   input wire logic pinBIn,
   output logic outputPinA,
   output logic outputPinAEn,
   output logic outputPinB,
   output logic outputPinBEn,
   output logic irq
);
   timer_pkg::word_t control_reg, control_next;
   timer_pkg::word_t counter_reg, counter_next;
   timer_pkg::word_t reload_reg, reload_next;
   timer_pkg::word_t compare_reg, compare_next;
   logic pinA_reg, pinA_next;
   logic pinB_reg, pinB_next;
   logic ack_reg, ack_next;
   logic [31:0] rdata_reg, rdata_next;
   logic pinASync, pinBSync, pinAPrev_reg, pinBPrev_reg;
   logic tick, countEvent, pwmMode, downDir, down_reg, down_next;
   logic wrStrobe, capture, extFall, cntEdge, reloadHit, underHit;
   logic ovfEvent, extEvent;

   timer_sync u_syncA (
      .clk(clk),
      .reset(reset),
      .din(pinAIn),
      .dout(pinASync)
   );
   timer_sync u_syncB (
      .clk(clk),
      .reset(reset),
      .din(pinBIn),
      .dout(pinBSync)
   );
   timer_prescaler u_pre (
      .clk(clk),
      .reset(reset),
      .prescaleSelect(control_reg[`BIT_PRESCALE_HI:`BIT_PRESCALE_LO]), // R8
      .tick(tick)
   );

   // merge only the two low byte lanes that sel enables
   function automatic timer_pkg::word_t mergeWord(input timer_pkg::word_t old,
                                                  input logic [31:0] dat, input logic [3:0] sel);
      mergeWord = old;
      if (sel[0]) mergeWord[7:0] = dat[7:0];
      if (sel[1]) mergeWord[15:8] = dat[15:8];
   endfunction

   always_comb begin
      // writes land on the edge at which the master sees ack high, not on the take edge
      wrStrobe = wb_cyc_i && wb_stb_i && wb_we_i && ack_reg;
      pwmMode = control_reg[`BIT_PWM_CLR] || control_reg[`BIT_PWM_SET];
      cntEdge = pinAPrev_reg && !pinASync;
      countEvent = control_reg[`BIT_RUN] &&
                   (control_reg[`BIT_COUNTER_MODE] ? cntEdge : tick);
      extFall = control_reg[`BIT_EXT_EN] && pinBPrev_reg && !pinBSync && !pwmMode;
      capture = control_reg[`BIT_CAPTURE];
      // outside PWM, down enable follows pin B; in PWM it bounces
      if (!control_reg[`BIT_DOWN_EN]) begin
         downDir = 1'b0;
      end else if (pwmMode) begin
         downDir = down_reg;
      end else begin
         downDir = !pinBSync;
      end
      reloadHit = !downDir && (counter_reg == reload_reg);
      underHit = downDir && (counter_reg == 16'h0000);
      ovfEvent = 1'b0;
      extEvent = 1'b0;
      counter_next = counter_reg;
      down_next = down_reg;
      reload_next = reload_reg;
      compare_next = compare_reg;
      pinA_next = pinA_reg;
      pinB_next = pinB_reg;
      control_next = control_reg;
      if (countEvent) begin
         if (reloadHit || underHit) begin
            ovfEvent = 1'b1; // R7
            if (pwmMode && control_reg[`BIT_DOWN_EN]) begin
               down_next = !down_reg;
               counter_next = down_reg ? counter_reg + 16'h0001 : counter_reg - 16'h0001;
            end else if (!capture) begin
               counter_next = downDir ? reload_reg : 16'h0000; // R6 R5
            end else begin
               counter_next = downDir ? 16'hFFFF : 16'h0000;
            end
            if (control_reg[`BIT_OUT_A_EN]) begin
               pinA_next = !pinA_reg; // R1 R2
            end
         end else begin
            counter_next = downDir ? counter_reg - 16'h0001 : counter_reg + 16'h0001;
         end
      end
      // pin B waveform in PWM mode; clear and set modes decode it from the count being stepped into,
      // so in clear mode the registered pin is already low on the compare count itself
      if (control_reg[`BIT_PWM_CLR] && control_reg[`BIT_PWM_SET]) begin
         if (counter_reg == compare_reg && countEvent) pinB_next = !pinB_reg;
      end else if (control_reg[`BIT_PWM_CLR]) begin
         if (counter_next == compare_reg) pinB_next = 1'b0; // R9 R4 R3
         else if (countEvent && (reloadHit || underHit)) pinB_next = 1'b1; // R9 R5
         else if (counter_next == 16'h0000) pinB_next = 1'b1; // R4
      end else if (control_reg[`BIT_PWM_SET]) begin
         if (counter_next == compare_reg) pinB_next = 1'b1;
         else if (countEvent && (reloadHit || underHit)) pinB_next = 1'b0;
      end
      if (extFall) begin
         extEvent = 1'b1;
         if (capture) reload_next = counter_reg;
         else counter_next = downDir ? reload_reg : 16'h0000;
      end
      if (ovfEvent) control_next[`BIT_OVF_FLAG] = 1'b1;
      if (extEvent) control_next[`BIT_EXT_FLAG] = 1'b1;
      if (wrStrobe) begin
         case (wb_adr_i)
            `ADDR_CONTROL: begin
               control_next = mergeWord(control_reg, wb_dat_i, wb_sel_i);
               // flags: write one clears, but a same-cycle event wins
               control_next[`BIT_OVF_FLAG] = ovfEvent ||
                  (control_reg[`BIT_OVF_FLAG] && !(wb_sel_i[0] && wb_dat_i[`BIT_OVF_FLAG]));
               control_next[`BIT_EXT_FLAG] = extEvent ||
                  (control_reg[`BIT_EXT_FLAG] && !(wb_sel_i[0] && wb_dat_i[`BIT_EXT_FLAG]));
            end
            `ADDR_COUNTER: counter_next = mergeWord(counter_reg, wb_dat_i, wb_sel_i); // R10
            `ADDR_RELOAD: reload_next = mergeWord(reload_reg, wb_dat_i, wb_sel_i); // R10
            `ADDR_COMPARE: compare_next = mergeWord(compare_reg, wb_dat_i, wb_sel_i); // R10
            default: ;
         endcase
      end
   end

   // classic wishbone: one wait state, ack for one cycle, unmapped reads zero
   always_comb begin
      ack_next = wb_cyc_i && wb_stb_i && !ack_reg;
      rdata_next = rdata_reg;
      if (ack_next) begin
         case (wb_adr_i)
            `ADDR_CONTROL: rdata_next = {16'h0000, control_reg};
            `ADDR_COUNTER: rdata_next = {16'h0000, counter_reg};
            `ADDR_RELOAD: rdata_next = {16'h0000, reload_reg};
            `ADDR_COMPARE: rdata_next = {16'h0000, compare_reg};
            default: rdata_next = 32'h0000_0000;
         endcase
      end
   end

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         control_reg <= `CONTROL_RESET;
         counter_reg <= `COUNTER_RESET;
         reload_reg <= `RELOAD_RESET;
         compare_reg <= `COMPARE_RESET;
         pinA_reg <= 1'b0;
         pinB_reg <= 1'b1;
         down_reg <= 1'b0;
         ack_reg <= 1'b0;
         rdata_reg <= 32'h0000_0000;
         pinAPrev_reg <= 1'b0;
         pinBPrev_reg <= 1'b0;
      end else begin
         control_reg <= control_next;
         counter_reg <= counter_next;
         reload_reg <= reload_next;
         compare_reg <= compare_next;
         pinA_reg <= pinA_next;
         pinB_reg <= pinB_next;
         down_reg <= down_next;
         ack_reg <= ack_next;
         rdata_reg <= rdata_next;
         pinAPrev_reg <= pinASync;
         pinBPrev_reg <= pinBSync;
      end
   end

   assign wb_ack_o = ack_reg;
   assign wb_dat_o = rdata_reg;
   assign outputPinA = pinA_reg;
   assign outputPinAEn = control_reg[`BIT_OUT_A_EN] && !control_reg[`BIT_COUNTER_MODE];
   assign outputPinB = pinB_reg;
   assign outputPinBEn = pwmMode;
   // interrupt enable bit gates the sticky flags
   assign irq = control_reg[`BIT_INT_EN] &&
                (control_reg[`BIT_OVF_FLAG] || control_reg[`BIT_EXT_FLAG]);

   a_flag_sticky: assert property (@(posedge clk) disable iff (reset)
      control_reg[`BIT_OVF_FLAG] && !wrStrobe |=> control_reg[`BIT_OVF_FLAG]) // R7
      else $error("overflow flag dropped without a write");
   a_reload_zero: assert property (@(posedge clk) disable iff (reset)
      countEvent && reloadHit && !capture && !control_reg[`BIT_DOWN_EN] && !wrStrobe && !extFall
      |=> counter_reg == 16'h0000) // R6
      else $error("counter did not reload to zero");
   a_ovf_set: assert property (@(posedge clk) disable iff (reset)
      countEvent && (reloadHit || underHit) |=> control_reg[`BIT_OVF_FLAG]) // R7
      else $error("overflow flag not set");
   a_pin_a_toggle: assert property (@(posedge clk) disable iff (reset)
      countEvent && reloadHit && control_reg[`BIT_OUT_A_EN] |=> outputPinA != $past(outputPinA)) // R1
      else $error("pin A did not toggle on reload");
   a_pwm_low: assert property (@(posedge clk) disable iff (reset)
      control_reg[`BIT_PWM_CLR] && !control_reg[`BIT_PWM_SET] && counter_reg == compare_reg
      && $changed(counter_reg) && !$past(wrStrobe)
      |-> !outputPinB) // R4
      else $error("pin B not low at compare");
   a_pwm_high: assert property (@(posedge clk) disable iff (reset)
      control_reg[`BIT_PWM_CLR] && !control_reg[`BIT_PWM_SET] && !control_reg[`BIT_DOWN_EN]
      && countEvent && reloadHit && compare_reg != 16'h0000
      |=> outputPinB) // R9
      else $error("pin B not high at reload");
   a_count_write: assert property (@(posedge clk) disable iff (reset)
      wrStrobe && wb_adr_i == `ADDR_COUNTER && !(countEvent && (reloadHit || underHit))
      && !control_reg[`BIT_OVF_FLAG] |=> !control_reg[`BIT_OVF_FLAG]) // R10
      else $error("counter write raised overflow");
   a_ack_pulse: assert property (@(posedge clk) disable iff (reset)
      wb_ack_o |=> !wb_ack_o) // R10
      else $error("ack held two cycles");

   // bus handshake: a fresh request is answered one clock later, and only once
   sequence s_bus_take;
      wb_cyc_i && wb_stb_i && !wb_ack_o;
   endsequence
   sequence s_bus_answer;
      wb_ack_o ##1 !wb_ack_o;
   endsequence
   a_bus_answer: assert property (@(posedge clk) disable iff (reset)
      s_bus_take |=> s_bus_answer) // R10
      else $error("bus request not answered once");

   // register writes land on the acknowledge edge with the lanes given
   a_reload_write: assert property (@(posedge clk) disable iff (reset)
      wrStrobe && wb_adr_i == `ADDR_RELOAD && wb_sel_i == 4'h3
      |=> {16'h0000, reload_reg} == ($past(wb_dat_i) & 32'h0000_FFFF)) // R10
      else $error("reload write did not land");
   a_compare_write: assert property (@(posedge clk) disable iff (reset)
      wrStrobe && wb_adr_i == `ADDR_COMPARE && wb_sel_i == 4'h3
      |=> {16'h0000, compare_reg} == ($past(wb_dat_i) & 32'h0000_FFFF)) // R10
      else $error("compare write did not land");
   a_counter_write: assert property (@(posedge clk) disable iff (reset)
      wrStrobe && wb_adr_i == `ADDR_COUNTER && wb_sel_i == 4'h3
      |=> {16'h0000, counter_reg} == ($past(wb_dat_i) & 32'h0000_FFFF)) // R10
      else $error("counter write did not land");

   // down count restarts from the reload value, up count from zero
   a_reload_down: assert property (@(posedge clk) disable iff (reset)
      countEvent && underHit && !capture && !pwmMode && !wrStrobe && !extFall
      |=> counter_reg == $past(reload_reg)) // R6
      else $error("counter did not reload on underflow");

   // the flag clears on a written one unless an overflow lands in the same clock
   a_flag_clear: assert property (@(posedge clk) disable iff (reset)
      wrStrobe && wb_adr_i == `ADDR_CONTROL && wb_sel_i[0] && wb_dat_i[`BIT_OVF_FLAG] && !ovfEvent
      |=> !control_reg[`BIT_OVF_FLAG]) // R7
      else $error("overflow flag not cleared by a written one");
   a_flag_set_wins: assert property (@(posedge clk) disable iff (reset)
      wrStrobe && wb_adr_i == `ADDR_CONTROL && ovfEvent |=> control_reg[`BIT_OVF_FLAG]) // R7
      else $error("overflow flag lost to a same-clock clear");

   // pin A only moves on a reload or underflow step
   a_pin_a_hold: assert property (@(posedge clk) disable iff (reset)
      !(countEvent && (reloadHit || underHit)) |=> $stable(outputPinA)) // R1
      else $error("pin A moved between reloads");

   // a stopped counter keeps its value unless software or the trigger pin moves it
   a_stop_hold: assert property (@(posedge clk) disable iff (reset)
      !control_reg[`BIT_RUN] && !wrStrobe && !extFall |=> $stable(counter_reg))
      else $error("stopped counter moved");

   // prescale codes zero, six and seven tick every clock
   a_tick_div1: assert property (@(posedge clk) disable iff (reset)
      control_reg[`BIT_PRESCALE_HI:`BIT_PRESCALE_LO] inside {3'h0, 3'h6, 3'h7} |-> tick) // R8
      else $error("prescaler skipped a clock at divisor one");

   // divide by four: three quiet clocks after each tick while the code stays at one
   sequence s_div4_quiet;
      (!tick || control_reg[`BIT_PRESCALE_HI:`BIT_PRESCALE_LO] != 3'h1) [*3];
   endsequence
   sequence s_div4_tick;
      tick || control_reg[`BIT_PRESCALE_HI:`BIT_PRESCALE_LO] != 3'h1;
   endsequence
   a_div4_gap: assert property (@(posedge clk) disable iff (reset)
      tick && control_reg[`BIT_PRESCALE_HI:`BIT_PRESCALE_LO] == 3'h1 |=> s_div4_quiet ##1 s_div4_tick) // R8
      else $error("divide by four tick spacing wrong");
endmodule

// *** testbench/tb.sv ***
`timescale 1ns/1ns
`include "timer_cfg.svh"
module tb;
   logic clk;
   logic reset;
   logic wbCyc;
   logic wbStb;
   logic wbWe;
   logic [3:0] wbAdr;
   logic [31:0] wbDatW;
   logic [31:0] wbDatR;
   logic wbAck;
   logic pinA;
   logic pinAEn;
   logic pinBDrv;
   logic pinB;
   logic pinBEn;
   logic irq;
   int n_fail;
   int total_checks;
   logic [31:0] rd;
   int n;
   int hi;
   int lo;

   timer_square_wave_pwm u_timer_square_wave_pwm (.clk(clk), .reset(reset), .wb_cyc_i(wbCyc), .wb_stb_i(wbStb),
      .wb_we_i(wbWe), .wb_adr_i(wbAdr), .wb_sel_i(4'h3), .wb_dat_i(wbDatW), .wb_dat_o(wbDatR), .wb_ack_o(wbAck),
      .pinAIn(1'b0), .pinBIn(pinBDrv), .outputPinA(pinA), .outputPinAEn(pinAEn), .outputPinB(pinB),
      .outputPinBEn(pinBEn), .irq(irq));

   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   task automatic report_and_stop;
      if (n_fail == 0 && total_checks > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         n_fail++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // classic single cycle; ack is looked at once settled, and the following edge is the one that samples it high
   task automatic wb(input logic we, input logic [3:0] adr, input logic [31:0] dat, output logic [31:0] q);
      int w;
      w = 0;
      @(posedge clk);
      wbCyc <= 1'b1;
      wbStb <= 1'b1;
      wbWe <= we;
      wbAdr <= adr;
      wbDatW <= dat;
      do begin
         @(posedge clk);
         #1;
         w++;
      end while (wbAck !== 1'b1 && w < 100);
      q = wbDatR;
      @(posedge clk);
      wbCyc <= 1'b0;
      wbStb <= 1'b0;
      if (w >= 100) chk(32'h0000_0000, 32'h0000_0001);
   endtask

   task automatic wr(input logic [3:0] adr, input logic [31:0] dat);
      logic [31:0] q;
      wb(1'b1, adr, dat, q);
   endtask

   // samples one step after the edge so the registered pins have settled
   task automatic wait_pin(input bit selB, input logic v, output int c);
      c = 0;
      do begin
         @(posedge clk);
         #1;
         c++;
      end while (((selB ? pinB : pinA) !== v) && c < 5000);
   endtask

   task automatic test_reset_regs;
      int i;
      for (i = 0; i < 4; i++) begin
         wb(1'b0, 4'(i * 4), 32'h0, rd);
         chk(rd, 32'h0000_0000);
      end
      chk({31'h0, pinB}, 32'h0000_0001);
      wr(4'h2, 32'h0000_FFFF);
      wb(1'b0, 4'h2, 32'h0, rd);
      chk(rd, 32'h0000_0000);
   endtask

   task automatic test_counter_write;
      wr(`ADDR_COUNTER, 32'h0000_1234);
      wb(1'b0, `ADDR_COUNTER, 32'h0, rd);
      chk(rd, 32'h0000_1234);
      wb(1'b0, `ADDR_CONTROL, 32'h0, rd);
      chk(rd, 32'h0000_0000);
   endtask

   // reload of 1 gives a reload every two ticks, so pin A toggles every 2*divisor clocks
   task automatic test_square_prescale;
      int divs [8] = '{1, 4, 16, 64, 256, 1024, 1, 1};
      int code;
      wr(`ADDR_COUNTER, 32'h0000_0000);
      wr(`ADDR_RELOAD, 32'h0000_0001);
      for (code = 0; code < 8; code++) begin
         wr(`ADDR_CONTROL, 32'h0000_0024 | (code << 8));
         wait_pin(1'b0, ~pinA, n);
         wait_pin(1'b0, ~pinA, n);
         chk(n, 2 * divs[code]);
         wait_pin(1'b0, ~pinA, n);
         chk(n, 2 * divs[code]);
         chk({pinAEn, pinBEn}, 32'h0000_0002);
      end
      // stop first so no overflow can land on the clearing write
      wr(`ADDR_CONTROL, 32'h0000_0000);
      wb(1'b0, `ADDR_CONTROL, 32'h0, rd);
      chk(rd & 32'h0000_0080, 32'h0000_0080);
      wr(`ADDR_CONTROL, 32'h0000_0080);
      wb(1'b0, `ADDR_CONTROL, 32'h0, rd);
      chk(rd, 32'h0000_0000);
   endtask

   // pin B low selects down count; reload 3 gives an underflow every four ticks
   task automatic test_down;
      wr(`ADDR_COUNTER, 32'h0000_0000);
      wr(`ADDR_RELOAD, 32'h0000_0003);
      @(posedge clk);
      pinBDrv <= 1'b0;
      repeat (3) @(posedge clk);
      wr(`ADDR_CONTROL, 32'h0000_0034);
      wait_pin(1'b0, ~pinA, n);
      wait_pin(1'b0, ~pinA, n);
      chk(n, 32'h0000_0004);
      wr(`ADDR_CONTROL, 32'h0000_0000);
      @(posedge clk);
      pinBDrv <= 1'b1;
   endtask

   // reload 9 gives a ten-tick period; compare 3 gives three high ticks
   task automatic test_pwm;
      wr(`ADDR_COUNTER, 32'h0000_0000);
      wr(`ADDR_RELOAD, 32'h0000_0009);
      wr(`ADDR_COMPARE, 32'h0000_0003);
      wr(`ADDR_CONTROL, 32'h0000_0804);
      wait_pin(1'b1, 1'b0, n);
      wait_pin(1'b1, 1'b1, n);
      wait_pin(1'b1, 1'b0, hi);
      wait_pin(1'b1, 1'b1, lo);
      chk(hi + lo, 32'h0000_000A);
      chk(hi, 32'h0000_0003);
      wait_pin(1'b1, 1'b0, hi);
      wait_pin(1'b1, 1'b1, lo);
      chk(lo, 32'h0000_0007);
      chk({pinAEn, pinBEn}, 32'h0000_0001);
      wr(`ADDR_CONTROL, 32'h0000_0080);
   endtask

   task automatic test_irq;
      wr(`ADDR_COUNTER, 32'h0000_0000);
      wr(`ADDR_RELOAD, 32'h0000_0001);
      wr(`ADDR_CONTROL, 32'h0000_0006);
      repeat (10) @(posedge clk);
      #1;
      chk({31'h0, irq}, 32'h0000_0001);
      wr(`ADDR_CONTROL, 32'h0000_0004);
      #1;
      chk({31'h0, irq}, 32'h0000_0000);
      wr(`ADDR_CONTROL, 32'h0000_0000);
      wr(`ADDR_CONTROL, 32'h0000_0082);
      #1;
      chk({31'h0, irq}, 32'h0000_0000);
      wb(1'b0, `ADDR_CONTROL, 32'h0, rd);
      chk(rd, 32'h0000_0002);
   endtask

   initial begin
      n_fail = 0;
      total_checks = 0;
      reset = 1'b1;
      wbCyc = 1'b0;
      wbStb = 1'b0;
      wbWe = 1'b0;
      wbAdr = 4'h0;
      wbDatW = 32'h0000_0000;
      pinBDrv = 1'b1;
      repeat (3) @(posedge clk);
      reset <= 1'b0;
      test_reset_regs();
      test_counter_write();
      test_square_prescale();
      test_down();
      test_pwm();
      test_irq();
      report_and_stop();
   end

   // the longest case, divisor 1024, needs a few thousand clocks
   initial begin
      repeat (30000) @(posedge clk);
      n_fail++;
      report_and_stop();
   end
endmodule
